// [src/card_clock_divider.sv]
// Card clock divider working on the sampled oscillator level.
// Assumes osc_level is registered and slower than half of ref_clk.
`timescale 1ns/1ns
`default_nettype none
`include "card_iface_regs.svh"
module card_clock_divider (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic osc_level,
    input wire logic enable,
    input wire logic [1:0] div_code,
    output logic div_clk
);
    logic osc_prev_q;
    logic [3:0] cnt_q;
    logic [3:0] half;

    always_comb begin
        case (div_code)
            `DIV_BY8: half = `HALF_BY8;
            `DIV_BY4: half = `HALF_BY4;
            default: half = `HALF_BY2;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            osc_prev_q <= 1'b0;
        end else begin
            osc_prev_q <= osc_level;
        end
    end

    // Counting both oscillator edges keeps the output at 50% duty
    always_ff @(posedge ref_clk) begin
        if (rst || !enable) begin
            cnt_q <= 4'h0;
            div_clk <= 1'b0;
        end else if (div_code == `DIV_BY1) begin
            cnt_q <= 4'h0;
            div_clk <= osc_level;
        end else if (osc_level != osc_prev_q) begin
            // Compare with >= so a shrinking ratio never overruns
            if (cnt_q >= half - 4'h1) begin
                cnt_q <= 4'h0;
                div_clk <= ~div_clk;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end
endmodule : card_clock_divider
`default_nettype wire

// [src/card_iface_pkg.sv]
// Types shared by the smart card host control block.
// Assumes nothing beyond the constants header.
package card_iface_pkg;
    // Gray along idle, power, io, clock, active, deactivate
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_POWER = 3'h1,
        ST_IO_ON = 3'h3,
        ST_CLK_ON = 3'h2,
        ST_ACTIVE = 3'h6,
        ST_DEACT = 3'h4
    } seq_state_t;
endpackage : card_iface_pkg

// [src/card_iface_regs.svh]
// Constants for the smart card host control block: bit positions,
// reset values, divider codes and timing counts.
// Assumes a 250 MHz ref_clk; all host pins synchronous to it.
//
// How it works
// - Select high: controls follow their pins directly.
// - Select low: control inputs latched and held.
// - Select low: host data lines released, pass nothing.
// - Select low: interrupt output tri-stated.
// - Mode low: sequencer drives card clock, reset.
// - Mode high: card clock copies strobe input.
// - Asynchronous mode ignores strobe input entirely.
// - Request low starts activation if card present.
// - Voltage select picks 5 V or 3 V.
// - Once enabled, card reset equals reset input.
// - Data passes between host and card lines.
// - Divide codes 00/01/10/11 give 8/1/4/2.
// - Divided clocks keep duty cycle near 50%.
// - Outside session interrupt shows card presence.
// - In session, fault drives interrupt low, deactivates.
// - Clock buffer output copies oscillator input.
// - Activation acts on request edges, not levels.
// - Over-current starts deactivation and reports fault.
`ifndef CARD_IFACE_REGS_SVH
`define CARD_IFACE_REGS_SVH

// Positions in the captured control vector
`define CTL_ACT_N 6
`define CTL_RST_IN 5
`define CTL_POWER_DOWN_REQ 4
`define CTL_VSEL 3
`define CTL_DIV_HI 2
`define CTL_DIV_LO 1
`define CTL_SYNC 0
`define CTL_WIDTH 7
`define CTL_RESET 7'h40

// Divide codes as {high, low}
`define DIV_BY8 2'h0
`define DIV_BY1 2'h1
`define DIV_BY4 2'h2
`define DIV_BY2 2'h3
// Oscillator transitions per half card period
`define HALF_BY8 4'h8
`define HALF_BY4 4'h4
`define HALF_BY2 4'h2

`define CLK_PERIOD_NS 4
`define STEP_TIME_NS 1000
`define STEP_CYCLES ((`STEP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STAB_TIME_MS 10
`define STAB_CYCLES ((`STAB_TIME_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [src/smart_card_host_control.sv]
// Host-side control of one smart card interface: select latching,
// activation sequencer, card clock and reset, data pass, interrupt.
// Assumes all inputs synchronous to ref_clk; open-drain wires are
// resolved outside from the out/oe pairs, pull-ups included.
`timescale 1ns/1ns
`default_nettype none
`include "card_iface_regs.svh"
module smart_card_host_control
    import card_iface_pkg::*;
#(
    parameter int STAB_CYCLES = `STAB_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic device_select,
    input wire logic activation_request_n,
    input wire logic card_reset_in,
    input wire logic power_down_req,
    input wire logic card_voltage_sel,
    input wire logic clock_divide_high,
    input wire logic clock_divide_low,
    input wire logic sync_mode_sel,
    input wire logic sync_card_clock_in,
    input wire logic oscillator_input,
    input wire logic card_present,
    input wire logic supply_fault,
    input wire logic over_temp,
    input wire logic over_current,
    input wire logic host_card_io_in,
    output logic host_card_io_out,
    output logic host_card_io_oe,
    input wire logic host_aux_io_a_in,
    output logic host_aux_io_a_out,
    output logic host_aux_io_a_oe,
    input wire logic host_aux_io_b_in,
    output logic host_aux_io_b_out,
    output logic host_aux_io_b_oe,
    input wire logic card_io_in,
    output logic card_io_out,
    output logic card_io_oe,
    input wire logic card_aux_c4_in,
    output logic card_aux_c4_out,
    output logic card_aux_c4_oe,
    input wire logic card_aux_c8_in,
    output logic card_aux_c8_out,
    output logic card_aux_c8_oe,
    output logic card_clk,
    output logic card_rst,
    output logic card_vcc_en,
    output logic card_vcc_5v,
    output logic presence_fault_irq_n_out,
    output logic presence_fault_irq_n_oe,
    output logic clock_buffer_out,
    output logic power_down_active
);
    localparam int STEP_MAX = `STEP_CYCLES + 2;

    logic [`CTL_WIDTH-1:0] ctl_pin;
    logic [`CTL_WIDTH-1:0] ctl_latch_q;
    logic [`CTL_WIDTH-1:0] ctl_eff;
    logic act_n_prev_q;
    logic act_fall;
    logic stab_done;
    logic [21:0] stab_cnt_q;
    seq_state_t state_q;
    logic [7:0] step_q;
    logic fault_now;
    logic fault_q;
    logic clk_en_q;
    logic io_en_q;
    logic rst_en_q;
    logic osc_q;
    logic div_clk;
    logic io_low_q;
    logic pass_en;
    logic [2:0] host_in_v;
    logic [2:0] card_in_v;
    logic [2:0] host_oe_v;
    logic [2:0] card_oe_v;

    assign ctl_pin = {activation_request_n, card_reset_in, power_down_req, card_voltage_sel,
                      clock_divide_high, clock_divide_low, sync_mode_sel};

    // Latch tracks the pins while selected, so deselect freezes the last value
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctl_latch_q <= `CTL_RESET;
        end else if (device_select) begin
            ctl_latch_q <= ctl_pin;
        end
    end

    assign ctl_eff = device_select ? ctl_pin : ctl_latch_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            act_n_prev_q <= 1'b1;
        end else begin
            act_n_prev_q <= ctl_eff[`CTL_ACT_N];
        end
    end

    assign act_fall = act_n_prev_q && !ctl_eff[`CTL_ACT_N];

    // Stabilization after power down; reset counts as already stable
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stab_cnt_q <= 22'h0;
        end else if (ctl_eff[`CTL_POWER_DOWN_REQ]) begin
            stab_cnt_q <= 22'(STAB_CYCLES);
        end else if (stab_cnt_q != 22'h0) begin
            stab_cnt_q <= stab_cnt_q - 22'h1;
        end
    end

    assign stab_done = (stab_cnt_q == 22'h0);

    assign fault_now = (state_q != ST_IDLE) &&
                       (!card_present || supply_fault || over_temp || over_current);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            step_q <= 8'h0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    // A level held low never restarts; power down gates it
                    if (act_fall && card_present && !ctl_eff[`CTL_POWER_DOWN_REQ] && stab_done) begin
                        state_q <= ST_POWER;
                        step_q <= 8'(`STEP_CYCLES);
                    end
                end
                ST_POWER, ST_IO_ON, ST_CLK_ON: begin
                    if (fault_now || ctl_eff[`CTL_ACT_N]) begin
                        state_q <= ST_DEACT;
                        step_q <= 8'(`STEP_CYCLES);
                    end else if (step_q == 8'h0) begin
                        step_q <= 8'(`STEP_CYCLES);
                        case (state_q)
                            ST_POWER: state_q <= ST_IO_ON;
                            ST_IO_ON: state_q <= ST_CLK_ON;
                            default: state_q <= ST_ACTIVE;
                        endcase
                    end else begin
                        step_q <= step_q - 8'h1;
                    end
                end
                ST_ACTIVE: begin
                    if (fault_now || ctl_eff[`CTL_ACT_N]) begin
                        state_q <= ST_DEACT;
                        step_q <= 8'(`STEP_CYCLES);
                    end
                end
                default: begin
                    if (step_q == 8'h0) begin
                        state_q <= ST_IDLE;
                    end else begin
                        step_q <= step_q - 8'h1;
                    end
                end
            endcase
        end
    end

    // Fault stays reported until the host withdraws its request; set wins
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fault_q <= 1'b0;
        end else begin
            fault_q <= fault_now || (fault_q && !ctl_eff[`CTL_ACT_N]);
        end
    end

    // Card stages; all enables drop in the same cycle on the way down
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            card_vcc_en <= 1'b0;
            card_vcc_5v <= 1'b0;
            io_en_q <= 1'b0;
            clk_en_q <= 1'b0;
            rst_en_q <= 1'b0;
        end else begin
            card_vcc_en <= (state_q != ST_IDLE) && (state_q != ST_DEACT);
            if (state_q == ST_IDLE) begin
                card_vcc_5v <= ctl_eff[`CTL_VSEL];
            end
            io_en_q <= (state_q == ST_IO_ON) || (state_q == ST_CLK_ON) ||
                       (state_q == ST_ACTIVE);
            clk_en_q <= (state_q == ST_CLK_ON) || (state_q == ST_ACTIVE);
            rst_en_q <= (state_q == ST_ACTIVE);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            card_rst <= 1'b0;
        end else begin
            card_rst <= rst_en_q && ctl_eff[`CTL_RST_IN];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            osc_q <= 1'b0;
            clock_buffer_out <= 1'b0;
        end else begin
            osc_q <= oscillator_input;
            clock_buffer_out <= oscillator_input;
        end
    end

    card_clock_divider u_div (
        .ref_clk(ref_clk),
        .rst(rst),
        .osc_level(osc_q),
        .enable(clk_en_q && !ctl_eff[`CTL_SYNC]),
        .div_code({ctl_eff[`CTL_DIV_HI], ctl_eff[`CTL_DIV_LO]}),
        .div_clk(div_clk)
    );

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            card_clk <= 1'b0;
        end else if (!clk_en_q) begin
            card_clk <= 1'b0;
        end else if (ctl_eff[`CTL_SYNC]) begin
            card_clk <= sync_card_clock_in;
        end else begin
            card_clk <= div_clk;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            presence_fault_irq_n_out <= 1'b0;
            presence_fault_irq_n_oe <= 1'b0;
            power_down_active <= 1'b0;
        end else begin
            presence_fault_irq_n_oe <= device_select;
            if (state_q != ST_IDLE || fault_q) begin
                presence_fault_irq_n_out <= !fault_q;
            end else begin
                presence_fault_irq_n_out <= card_present && stab_done;
            end
            power_down_active <= ctl_eff[`CTL_POWER_DOWN_REQ];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            io_low_q <= 1'b0;
        end else begin
            io_low_q <= 1'b0;
        end
    end

    assign pass_en = io_en_q && device_select;
    assign host_in_v = {host_aux_io_b_in, host_aux_io_a_in, host_card_io_in};
    assign card_in_v = {card_aux_c8_in, card_aux_c4_in, card_io_in};

    // Whichever side pulls low first owns the lane until it releases;
    // this blocks the echo of our own drive from latching up the lane
    genvar g;
    for (g = 0; g < 3; g++) begin : lane
        logic drv_card_q;
        logic drv_host_q;
        always_ff @(posedge ref_clk) begin
            if (rst || !pass_en) begin
                drv_card_q <= 1'b0;
                drv_host_q <= 1'b0;
            end else if (drv_card_q) begin
                drv_card_q <= !host_in_v[g];
            end else if (drv_host_q) begin
                drv_host_q <= !card_in_v[g];
            end else begin
                drv_card_q <= !host_in_v[g];
                drv_host_q <= host_in_v[g] && !card_in_v[g];
            end
        end
        assign card_oe_v[g] = drv_card_q;
        assign host_oe_v[g] = drv_host_q;
    end

    assign host_card_io_out = io_low_q;
    assign host_aux_io_a_out = io_low_q;
    assign host_aux_io_b_out = io_low_q;
    assign card_io_out = io_low_q;
    assign card_aux_c4_out = io_low_q;
    assign card_aux_c8_out = io_low_q;
    assign host_card_io_oe = host_oe_v[0];
    assign host_aux_io_a_oe = host_oe_v[1];
    assign host_aux_io_b_oe = host_oe_v[2];
    assign card_io_oe = card_oe_v[0];
    assign card_aux_c4_oe = card_oe_v[1];
    assign card_aux_c8_oe = card_oe_v[2];

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence s_start_power;
        state_q == ST_IDLE ##1 state_q == ST_POWER;
    endsequence

    sequence s_fault_hit;
        state_q == ST_ACTIVE && fault_now;
    endsequence

    AST_IRQ_RELEASE: assert property (
        !device_select |=> !presence_fault_irq_n_oe)
        else $error("interrupt driven while deselected");

    AST_IO_RELEASE: assert property (
        !device_select |=> (host_oe_v == 3'h0) && (card_oe_v == 3'h0))
        else $error("data lane driven while deselected");

    AST_LATCH_HOLD: assert property (
        !device_select && !$past(device_select) |-> $stable(ctl_eff))
        else $error("latched controls changed while deselected");

    AST_SYNC_CLK: assert property (
        clk_en_q && ctl_eff[`CTL_SYNC] |=> card_clk == $past(sync_card_clock_in))
        else $error("card clock not following strobe");

    AST_RST_FOLLOW: assert property (
        rst_en_q |=> card_rst == $past(ctl_eff[`CTL_RST_IN]))
        else $error("card reset not following reset input");

    AST_NO_CARD: assert property (
        state_q == ST_IDLE && !card_present |=> state_q == ST_IDLE)
        else $error("activation without a card");

    AST_EDGE_ONLY: assert property (
        state_q == ST_IDLE && !act_fall |=> state_q == ST_IDLE)
        else $error("activation without a request edge");

    AST_FAULT_DEACT: assert property (
        s_fault_hit |=> state_q == ST_DEACT ##1 !presence_fault_irq_n_out)
        else $error("fault did not deactivate and report");

    AST_PRESENCE: assert property (
        state_q == ST_IDLE && !fault_q && stab_done |=>
            presence_fault_irq_n_out == $past(card_present))
        else $error("presence not reported outside session");

    AST_POWER_STEP: assert property (
        s_start_power |-> ##[1:STEP_MAX] (state_q == ST_IO_ON || state_q == ST_DEACT))
        else $error("sequencer stuck in power step");

    AST_ASYNC_IGNORE: assert property (
        clk_en_q && !ctl_eff[`CTL_SYNC] |=> card_clk == $past(div_clk))
        else $error("async card clock not from divider");
endmodule : smart_card_host_control
`default_nettype wire

// [tb/open_drain_lanes.sv]
// Pull-up model of the six open-drain data lanes, host and card side.
// Assumes each party reports a pull-low as a one-bit drive flag.
`timescale 1ns/1ns
`default_nettype none
module open_drain_lanes (
    input wire logic [2:0] host_pull,
    input wire logic [2:0] dut_host_oe,
    input wire logic [2:0] card_pull,
    input wire logic [2:0] dut_card_oe,
    output logic [2:0] host_wire,
    output logic [2:0] card_wire
);
    // Released lanes float to the weak pull-up
    assign host_wire = ~(host_pull | dut_host_oe);
    assign card_wire = ~(card_pull | dut_card_oe);
endmodule : open_drain_lanes
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the smart card host control block.
// Assumes the pull-up lane model; stabilization shortened to 20 cycles.
`timescale 1ns/1ns
`default_nettype none
`define CHECK_EQ(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
    import card_iface_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, sel = 1'b1, act_n = 1'b1, rst_in = 1'b0;
    logic pd = 1'b0, vsel = 1'b0, div_hi = 1'b1, div_lo = 1'b1, sync = 1'b0;
    logic strobe = 1'b0, osc = 1'b0, osc_run = 1'b0, present = 1'b0, ovc = 1'b0;
    logic [2:0] host_pull = 3'h0, card_pull = 3'h0;
    // Nets, since the block drives these one bit per port
    wire logic [2:0] host_oe, card_oe, host_out, card_out;
    logic [2:0] host_wire, card_wire;
    logic card_clk, card_rst, vcc_en, vcc_5v, irq_out, irq_oe, buf_out, pd_act, v;
    logic [1:0] osc_cnt = 2'h0;
    int num_errors = 0, checks = 0;
    always #2 ref_clk = ~ref_clk;
    // Oscillator at a quarter of ref_clk keeps under the sampling limit
    always @(posedge ref_clk) begin
        osc_cnt <= osc_cnt + 2'h1;
        if (osc_run && osc_cnt[0]) osc <= ~osc;
    end
    smart_card_host_control #(.STAB_CYCLES(20)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .device_select(sel), .activation_request_n(act_n),
        .card_reset_in(rst_in), .power_down_req(pd), .card_voltage_sel(vsel),
        .clock_divide_high(div_hi), .clock_divide_low(div_lo), .sync_mode_sel(sync),
        .sync_card_clock_in(strobe), .oscillator_input(osc), .card_present(present),
        .supply_fault(1'b0), .over_temp(1'b0), .over_current(ovc),
        .host_card_io_in(host_wire[0]), .host_card_io_out(host_out[0]),
        .host_card_io_oe(host_oe[0]), .host_aux_io_a_in(host_wire[1]),
        .host_aux_io_a_out(host_out[1]), .host_aux_io_a_oe(host_oe[1]),
        .host_aux_io_b_in(host_wire[2]), .host_aux_io_b_out(host_out[2]),
        .host_aux_io_b_oe(host_oe[2]), .card_io_in(card_wire[0]),
        .card_io_out(card_out[0]), .card_io_oe(card_oe[0]),
        .card_aux_c4_in(card_wire[1]), .card_aux_c4_out(card_out[1]),
        .card_aux_c4_oe(card_oe[1]), .card_aux_c8_in(card_wire[2]),
        .card_aux_c8_out(card_out[2]), .card_aux_c8_oe(card_oe[2]),
        .card_clk(card_clk), .card_rst(card_rst), .card_vcc_en(vcc_en),
        .card_vcc_5v(vcc_5v), .presence_fault_irq_n_out(irq_out),
        .presence_fault_irq_n_oe(irq_oe), .clock_buffer_out(buf_out),
        .power_down_active(pd_act)
    );
    open_drain_lanes lanes_u (
        .host_pull(host_pull), .dut_host_oe(host_oe), .card_pull(card_pull),
        .dut_card_oe(card_oe), .host_wire(host_wire), .card_wire(card_wire)
    );
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    task wait_until(input int which, input logic val, input int lim);
        int i;
        logic s;
        begin
            s = 1'bx;
            for (i = 0; i <= lim; i++) begin
                s = (which == 0) ? vcc_en : (which == 1) ? card_rst : card_clk;
                if (s === val) break;
                tick(1);
            end
            `CHECK_EQ(s, val);
        end
    endtask : wait_until
    task meas(input int per);
        int h, l;
        begin
            h = 0;
            l = 0;
            wait_until(2, 1'b0, 100);
            wait_until(2, 1'b1, 100);
            while (card_clk === 1'b1 && h < 100) begin tick(1); h++; end
            while (card_clk === 1'b0 && l < 100) begin tick(1); l++; end
            `CHECK_EQ(h + l, per);
            if (per > 4) `CHECK_EQ(h, per / 2);
        end
    endtask : meas
    task print_verdict;
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    initial begin
        // Whole sequence needs about 2000 cycles
        #80000;
        num_errors++;
        print_verdict();
    end
    int i;
    int divs[4] = '{8, 1, 4, 2};
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        present <= 1'b1;
        vsel <= 1'b1;
        rst_in <= 1'b1;
        osc_run <= 1'b1;
        tick(3);
        `CHECK_EQ(irq_out, 1'b1);
        `CHECK_EQ(irq_oe, 1'b1);
        @(posedge ref_clk) act_n <= 1'b0;
        wait_until(0, 1'b1, 20);
        `CHECK_EQ(vcc_5v, 1'b1);
        wait_until(1, 1'b1, 1000);
        @(posedge ref_clk) rst_in <= 1'b0;
        tick(3);
        `CHECK_EQ(card_rst, 1'b0);
        $display("activation done");
        for (i = 0; i < 6; i++) begin
            @(posedge ref_clk);
            if (i < 3) host_pull[i] <= 1'b1;
            else card_pull[i - 3] <= 1'b1;
            tick(3);
            if (i < 3) begin
                `CHECK_EQ(card_wire[i], 1'b0);
            end else begin
                `CHECK_EQ(host_wire[i - 3], 1'b0);
            end
            @(posedge ref_clk) host_pull <= 3'h0;
            card_pull <= 3'h0;
            tick(4);
            `CHECK_EQ({host_oe, card_oe}, 6'h00);
        end
        `CHECK_EQ({host_out, card_out}, 6'h00);
        $display("data lanes done");
        for (i = 0; i < 4; i++) begin
            @(posedge ref_clk) {div_hi, div_lo} <= i[1:0];
            tick(80);
            meas(4 * divs[i]);
        end
        $display("divider done");
        @(posedge ref_clk) sync <= 1'b1;
        for (i = 0; i < 4; i++) begin
            @(posedge ref_clk) strobe <= ~i[0];
            tick(3);
            `CHECK_EQ(card_clk, ~i[0]);
        end
        @(posedge ref_clk) sync <= 1'b0;
        osc_run <= 1'b0;
        tick(40);
        v = card_clk;
        `CHECK_EQ(buf_out, osc);
        for (i = 0; i < 6; i++) begin
            @(posedge ref_clk) strobe <= i[0];
            tick(2);
            `CHECK_EQ(card_clk, v);
        end
        @(posedge ref_clk) osc_run <= 1'b1;
        tick(4);
        // Buffer lags the oscillator by one edge
        for (i = 0; i < 4; i++) begin
            v = osc;
            tick(1);
            `CHECK_EQ(buf_out, v);
        end
        $display("clock modes done");
        @(posedge ref_clk) rst_in <= 1'b1;
        tick(3);
        @(posedge ref_clk) sel <= 1'b0;
        tick(2);
        @(posedge ref_clk) rst_in <= 1'b0;
        host_pull <= 3'h7;
        tick(4);
        `CHECK_EQ(card_rst, 1'b1);
        `CHECK_EQ(irq_oe, 1'b0);
        `CHECK_EQ(card_oe, 3'h0);
        @(posedge ref_clk) sel <= 1'b1;
        host_pull <= 3'h0;
        tick(4);
        `CHECK_EQ(card_rst, 1'b0);
        `CHECK_EQ(irq_oe, 1'b1);
        $display("select done");
        @(posedge ref_clk) ovc <= 1'b1;
        tick(4);
        `CHECK_EQ(irq_out, 1'b0);
        `CHECK_EQ(vcc_en, 1'b0);
        @(posedge ref_clk) ovc <= 1'b0;
        tick(300);
        `CHECK_EQ(vcc_en, 1'b0);
        @(posedge ref_clk) act_n <= 1'b1;
        tick(3);
        `CHECK_EQ(irq_out, 1'b1);
        $display("fault done");
        @(posedge ref_clk) pd <= 1'b1;
        tick(3);
        `CHECK_EQ(pd_act, 1'b1);
        @(posedge ref_clk) act_n <= 1'b0;
        tick(10);
        `CHECK_EQ(vcc_en, 1'b0);
        @(posedge ref_clk) act_n <= 1'b1;
        pd <= 1'b0;
        vsel <= 1'b0;
        tick(3);
        `CHECK_EQ(irq_out, 1'b0);
        tick(30);
        `CHECK_EQ(irq_out, 1'b1);
        @(posedge ref_clk) act_n <= 1'b0;
        wait_until(0, 1'b1, 20);
        `CHECK_EQ(vcc_5v, 1'b0);
        @(posedge ref_clk) act_n <= 1'b1;
        tick(300);
        `CHECK_EQ(vcc_en, 1'b0);
        $display("power down done");
        @(posedge ref_clk) present <= 1'b0;
        tick(3);
        `CHECK_EQ(irq_out, 1'b0);
        @(posedge ref_clk) act_n <= 1'b0;
        tick(10);
        `CHECK_EQ(vcc_en, 1'b0);
        $display("no card done");
        print_verdict();
    end
endmodule : tb
`default_nettype wire
